// ===== hdl/gbr_pkg.sv
// Operation
// - writing one to control bit 15 starts soft reset; bit self-clears when done
// - control bit 14 selects digital loopback; resets to zero
// - forced speed from bits 6 and 13; bit 6 read-only, resets one
// - control bit 12 enables autoneg, resets one; forced speed and duplex ignored then
// - writing one to control bit 9 restarts autoneg; bit self-clears
// - control bit 8 forces full duplex only while autoneg disabled; resets zero
// - status bits 14 to 11 read one for 100TX and 10T abilities
// - status bits 15, 10 and 9 read zero
// - status bit 8 reads one; index 15 holds no extended status register and reads zero
// - status bit 5 shows autoneg complete; resets zero
// - status bit 4 shows remote fault detected
// - status bit 3 reads one, autoneg able
// - status bit 2 is link status, latching low, resets zero
// - status bit 1 shows jabber detected
// - status bit 0 reads one, extended capabilities supported
// - first identifier register returns oui bits 3 to 18 read-only
// - second identifier: oui bits read-only, writable model and revision
// - advertisement next page, remote fault, pause flags writable, reset zero
// - advertisement ability bits 8 to 5 writable, reset one
// - selector field bits 4:0 writable, resets to ieee 802.3 code
// - indexes 16 to 31 are unmapped: they read zero and ignore writes
package gbr_pkg;
  localparam logic [4:0]  IDX_CTRL        = 5'h00;
  localparam logic [4:0]  IDX_STAT        = 5'h01;
  localparam logic [4:0]  IDX_ID_HI       = 5'h02;
  localparam logic [4:0]  IDX_ID_LO       = 5'h03;
  localparam logic [4:0]  IDX_ADV         = 5'h04;
  localparam int          CB_RESET        = 15;
  localparam int          CB_LOOP         = 14;
  localparam int          CB_SPD0         = 13;
  localparam int          CB_ANEN         = 12;
  localparam int          CB_PWDN         = 11;
  localparam int          CB_RESTART      = 9;
  localparam int          CB_DUPLEX       = 8;
  localparam int          CB_SPD1         = 6;
  localparam int          SB_ANDONE       = 5;
  localparam int          SB_RFAULT       = 4;
  localparam int          SB_LINK         = 2;
  localparam int          SB_JABBER       = 1;
  // fixed status bits: 14..11, 8, 3, 0 set; 15, 10, 9 clear
  localparam logic [15:0] STAT_FIXED      = 16'h7909;
  localparam logic [15:0] ADV_WMASK       = 16'hadff;
  localparam logic [15:0] ADV_RSVD_MASK   = 16'h5200;
  localparam logic [15:0] STAT_CHK_MASK   = 16'hffc9;
  localparam logic [15:0] CTRL_RO_MASK    = 16'h0040;
  localparam logic [15:0] CTRL_RD_MASK    = 16'hfb40;
  localparam logic [15:0] ADV_RESET       = 16'h01e1;
  localparam logic [15:0] CTRL_RESET      = 16'h1040;
  localparam logic [15:0] CTRL_RW_MASK    = 16'h7900;
  localparam logic [5:0]  MODEL_RESET     = 6'h01;  // arbitrary value
  localparam logic [3:0]  REV_RESET       = 4'h0;   // arbitrary value
  localparam logic [1:0]  SPD_10          = 2'b00;
  localparam logic [1:0]  SPD_100         = 2'b01;
  localparam logic [1:0]  SPD_1000        = 2'b10;
  localparam int          SRST_CYCLES     = 4;
  typedef enum logic [1:0] {SPEED_10, SPEED_100, SPEED_1000, SPEED_RSVD} gbr_speed_t;
endpackage : gbr_pkg

// ===== hdl/gbr_regs.sv
`timescale 1ns/1ns
module gbr_regs import gbr_pkg::*; #(
  parameter logic [15:0] OUI_HI = 16'h0123,  // arbitrary value
  parameter logic [5:0]  OUI_LO = 6'h15      // arbitrary value
) (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic [4:0]  reg_index,
  input  wire logic        reg_wr,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  input  wire logic        an_complete,
  input  wire logic        remote_fault,
  input  wire logic        link_up,
  input  wire logic        jabber,
  output logic             phy_soft_reset,
  output logic             an_restart,
  output logic             loopback,
  output logic             power_down,
  output logic             an_enable,
  output logic             full_duplex,
  output logic      [1:0]  speed,
  output logic      [15:0] adv_word
);
  logic [15:0] ctrl;
  logic [5:0]  model;
  logic [3:0]  rev;
  logic [15:0] adv;
  logic [2:0]  srst_cnt;
  logic        link_ll;
  logic        an_s1;
  logic        an_s2;
  logic        rf_s1;
  logic        rf_s2;
  logic        ln_s1;
  logic        ln_s2;
  logic        jb_s1;
  logic        jb_s2;
  logic        rd_stat;
  logic        soft_rst_done;

  function automatic logic hit(input logic [4:0] idx, input logic [4:0] want);
    hit = (idx[3:0] == want[3:0]) && !idx[4];
  endfunction : hit

  // two-flop synchronisers, one per status pin
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      an_s1 <= 1'b0;
      an_s2 <= 1'b0;
    end else begin
      an_s1 <= an_complete;
      an_s2 <= an_s1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rf_s1 <= 1'b0;
      rf_s2 <= 1'b0;
    end else begin
      rf_s1 <= remote_fault;
      rf_s2 <= rf_s1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      ln_s1 <= 1'b0;
      ln_s2 <= 1'b0;
    end else begin
      ln_s1 <= link_up;
      ln_s2 <= ln_s1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      jb_s1 <= 1'b0;
      jb_s2 <= 1'b0;
    end else begin
      jb_s1 <= jabber;
      jb_s2 <= jb_s1;
    end
  end

  assign soft_rst_done = ctrl[CB_RESET] && (srst_cnt == 3'(SRST_CYCLES - 1));
  assign rd_stat       = !reg_wr && hit(reg_index, IDX_STAT);

  // soft reset counter counts up to SRST_CYCLES - 1; bit clears when done and restores defaults
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      srst_cnt <= 3'h0;
    end else if (ctrl[CB_RESET]) begin
      srst_cnt <= soft_rst_done ? 3'h0 : srst_cnt + 3'h1;
    end
  end

  // control word; soft reset completion restores every default
  always_ff @(posedge sys_clk) begin
    if (!resetn || soft_rst_done) begin
      ctrl <= CTRL_RESET;
    end else begin
      ctrl[CB_RESTART] <= 1'b0;
      if (reg_wr && hit(reg_index, IDX_CTRL)) begin
        ctrl[CB_RESET]   <= ctrl[CB_RESET] | reg_wdata[CB_RESET];
        ctrl[CB_LOOP]    <= reg_wdata[CB_LOOP];
        ctrl[CB_SPD0]    <= reg_wdata[CB_SPD0];
        ctrl[CB_ANEN]    <= reg_wdata[CB_ANEN];
        ctrl[CB_PWDN]    <= reg_wdata[CB_PWDN];
        ctrl[CB_RESTART] <= reg_wdata[CB_RESTART];
        ctrl[CB_DUPLEX]  <= reg_wdata[CB_DUPLEX];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn || soft_rst_done) begin
      model <= MODEL_RESET;
      rev   <= REV_RESET;
    end else if (reg_wr && hit(reg_index, IDX_ID_LO)) begin
      model <= reg_wdata[9:4];
      rev   <= reg_wdata[3:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn || soft_rst_done) begin
      adv <= ADV_RESET;
    end else if (reg_wr && hit(reg_index, IDX_ADV)) begin
      adv <= reg_wdata & ADV_WMASK;
    end
  end

  // latching low: a drop is held until status is read
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      link_ll <= 1'b0;
    end else if (!ln_s2) begin
      link_ll <= 1'b0;
    end else if (rd_stat) begin
      link_ll <= 1'b1;
    end
  end

  always_comb begin
    reg_rdata = 16'h0000;
    if (!reg_wr) begin
      if (hit(reg_index, IDX_CTRL)) begin
        reg_rdata = (ctrl & CTRL_RW_MASK) | {ctrl[CB_RESET], 5'h00, ctrl[CB_RESTART], 9'h000};
        reg_rdata = reg_rdata | (CTRL_RESET & CTRL_RO_MASK);
      end else if (hit(reg_index, IDX_STAT)) begin
        reg_rdata = STAT_FIXED;
        reg_rdata[SB_ANDONE] = an_s2;
        reg_rdata[SB_RFAULT] = rf_s2;
        reg_rdata[SB_LINK]   = link_ll && ln_s2;
        reg_rdata[SB_JABBER] = jb_s2;
      end else if (hit(reg_index, IDX_ID_HI)) begin
        reg_rdata = OUI_HI;
      end else if (hit(reg_index, IDX_ID_LO)) begin
        reg_rdata = {OUI_LO, model, rev};
      end else if (hit(reg_index, IDX_ADV)) begin
        reg_rdata = adv;
      end
    end
  end

  assign phy_soft_reset = ctrl[CB_RESET];
  assign an_restart     = ctrl[CB_RESTART];
  assign loopback       = ctrl[CB_LOOP];
  assign power_down     = ctrl[CB_PWDN];
  assign an_enable      = ctrl[CB_ANEN];
  assign full_duplex    = ctrl[CB_ANEN] ? 1'b0 : ctrl[CB_DUPLEX];
  assign speed          = ctrl[CB_ANEN] ? SPD_1000 : {1'b1, ctrl[CB_SPD0]};
  assign adv_word       = adv;

  // register writes that are not swallowed by a finishing soft reset
  sequence ctrl_write_s;
    reg_wr && hit(reg_index, IDX_CTRL) && !soft_rst_done;
  endsequence

  sequence id_write_s;
    reg_wr && hit(reg_index, IDX_ID_LO) && !soft_rst_done;
  endsequence

  sequence adv_write_s;
    reg_wr && hit(reg_index, IDX_ADV) && !soft_rst_done;
  endsequence

  sequence srst_start_s;
    !ctrl[CB_RESET] ##1 ctrl[CB_RESET];
  endsequence

  sequence srst_hold_s;
    ctrl[CB_RESET] [*4];
  endsequence

  srst_clear_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    $rose(ctrl[CB_RESET]) |-> ##[1:8] !ctrl[CB_RESET])
    else $error("soft reset stuck");
  srst_len_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    srst_start_s |-> srst_hold_s ##1 !ctrl[CB_RESET])
    else $error("soft reset length wrong");
  srst_defaults_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    soft_rst_done |=> ctrl == CTRL_RESET && adv == ADV_RESET && model == MODEL_RESET && rev == REV_RESET)
    else $error("soft reset defaults wrong");
  srst_sticky_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    ctrl[CB_RESET] && !soft_rst_done |=> ctrl[CB_RESET])
    else $error("soft reset aborted");

  loop_reset_a: assert property (@(posedge sys_clk)
    !resetn |=> !loopback && an_enable)
    else $error("control reset bad");
  loop_write_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    ctrl_write_s |=> loopback == $past(reg_wdata[CB_LOOP]))
    else $error("loopback write lost");
  spd_write_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    ctrl_write_s |=> ctrl[CB_SPD0] == $past(reg_wdata[CB_SPD0]))
    else $error("speed write lost");
  speed_forced_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    !an_enable |-> speed[1] && speed[0] == ctrl[CB_SPD0])
    else $error("forced speed wrong");
  ctrl_ro_one_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    !reg_wr && hit(reg_index, IDX_CTRL) |-> reg_rdata[CB_SPD1])
    else $error("speed upper bit not one");
  an_override_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    an_enable |-> !full_duplex && speed == SPD_1000)
    else $error("forced mode leaked");
  anen_write_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    ctrl_write_s |=> an_enable == $past(reg_wdata[CB_ANEN]))
    else $error("autoneg enable write lost");
  pwdn_write_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    ctrl_write_s |=> power_down == $past(reg_wdata[CB_PWDN]))
    else $error("power down write lost");

  restart_pulse_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    ctrl[CB_RESTART] |=> !ctrl[CB_RESTART])
    else $error("restart not self clearing");
  restart_write_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    ctrl_write_s ##0 reg_wdata[CB_RESTART] |=> an_restart)
    else $error("restart not started");
  restart_src_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    an_restart |-> $past(reg_wr && hit(reg_index, IDX_CTRL) && reg_wdata[CB_RESTART] && !soft_rst_done))
    else $error("restart without write");
  duplex_forced_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    !an_enable |-> full_duplex == ctrl[CB_DUPLEX])
    else $error("duplex not forced");
  duplex_write_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    ctrl_write_s |=> ctrl[CB_DUPLEX] == $past(reg_wdata[CB_DUPLEX]))
    else $error("duplex write lost");

  stat_fixed_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    rd_stat |-> (reg_rdata & STAT_CHK_MASK) == STAT_FIXED)
    else $error("fixed status bad");
  stat_zero_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    rd_stat |-> (reg_rdata & STAT_CHK_MASK & ~STAT_FIXED) == '0)
    else $error("unsupported ability shown");
  stat_ones_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    rd_stat |-> (reg_rdata & STAT_FIXED) == STAT_FIXED)
    else $error("ability bit missing");
  stat_andone_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    rd_stat |-> reg_rdata[SB_ANDONE] == an_s2)
    else $error("autoneg done not shown");
  stat_rfault_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    rd_stat |-> reg_rdata[SB_RFAULT] == rf_s2)
    else $error("remote fault not shown");
  stat_jabber_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    rd_stat |-> reg_rdata[SB_JABBER] == jb_s2)
    else $error("jabber not shown");

  link_latch_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    !ln_s2 |=> !link_ll)
    else $error("link drop not latched");
  stat_link_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    rd_stat && !ln_s2 |-> !reg_rdata[SB_LINK])
    else $error("link shown while down");
  link_rearm_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    rd_stat && ln_s2 |=> link_ll)
    else $error("link latch not rearmed");
  link_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    !link_ll && !rd_stat |=> !link_ll)
    else $error("link latch released early");

  id_read_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (!reg_wr && hit(reg_index, IDX_ID_HI)) |-> reg_rdata == OUI_HI)
    else $error("id high bad");
  id_oui_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    !reg_wr && hit(reg_index, IDX_ID_LO) |-> reg_rdata[15:10] == OUI_LO)
    else $error("id low oui bad");
  id_lo_read_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    !reg_wr && hit(reg_index, IDX_ID_LO) |-> reg_rdata[9:0] == {model, rev})
    else $error("id low fields bad");
  id_write_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    id_write_s |=> {model, rev} == $past(reg_wdata[9:0]))
    else $error("id low write lost");

  adv_write_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    adv_write_s |=> adv == ($past(reg_wdata) & ADV_WMASK))
    else $error("advert write lost");
  adv_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    !(reg_wr && hit(reg_index, IDX_ADV)) && !soft_rst_done |=> $stable(adv))
    else $error("advert changed unasked");
  adv_read_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    !reg_wr && hit(reg_index, IDX_ADV) |-> reg_rdata == adv_word)
    else $error("advert read bad");
  adv_rsvd_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (adv & ADV_RSVD_MASK) == '0)
    else $error("reserved adv bit set");
  ctrl_rsvd_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    !reg_wr && hit(reg_index, IDX_CTRL) |-> (reg_rdata & ~CTRL_RD_MASK) == '0)
    else $error("reserved control bit set");
  wr_quiet_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    reg_wr |-> reg_rdata == '0)
    else $error("read data during write");
  unmapped_rd_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    !reg_wr && reg_index[4] |-> reg_rdata == '0)
    else $error("unmapped index answered");
endmodule : gbr_regs

// ===== tb/gbr_mac_model.sv
`timescale 1ns/1ns
module gbr_mac_model (
  input  wire logic        sys_clk,
  output logic      [4:0]  reg_index,
  output logic             reg_wr,
  output logic      [15:0] reg_wdata,
  input  wire logic [15:0] reg_rdata
);
  initial begin
    reg_index = 5'h00;
    reg_wr    = 1'b0;
    reg_wdata = 16'h0000;
  end
  // write held up to the taking edge, data scrambled after release
  task automatic wr(input logic [4:0] i, input logic [15:0] d);
    @(posedge sys_clk);
    reg_index <= i;
    reg_wr    <= 1'b1;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
    reg_wdata <= ~d;
  endtask : wr
  task automatic rd(input logic [4:0] i, output logic [15:0] d);
    @(posedge sys_clk);
    reg_index <= i;
    @(negedge sys_clk);
    d = reg_rdata;
    // park on an unmapped index so a held status index is not a second read
    @(posedge sys_clk);
    reg_index <= 5'h1f;
  endtask : rd
endmodule : gbr_mac_model

// ===== tb/tb_gbr_regs.sv
`timescale 1ns/1ns
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin errors++; $display("ERROR %s exp %h got %h", n, e, g); end end
module tb_gbr_regs import gbr_pkg::*; ;
  localparam logic [15:0] T_OUI_HI = 16'h0a5c;  // arbitrary value
  localparam logic [5:0]  T_OUI_LO = 6'h2b;     // arbitrary value
  logic        sys_clk = 1'b0;
  logic        resetn = 1'b0;
  logic [4:0]  reg_index;
  logic        reg_wr;
  logic [15:0] reg_wdata, reg_rdata, adv_word, v;
  logic        an_complete = 1'b0, remote_fault = 1'b0, link_up = 1'b0, jabber = 1'b0;
  logic        phy_soft_reset, an_restart, loopback, power_down, an_enable, full_duplex;
  logic [1:0]  speed;
  int          errors = 0, total_checks = 0, n;
  always #10 sys_clk = ~sys_clk;
  gbr_mac_model gbr_mac_model_inst (.sys_clk(sys_clk), .reg_index(reg_index), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  gbr_regs #(.OUI_HI(T_OUI_HI), .OUI_LO(T_OUI_LO)) gbr_regs_inst (.sys_clk(sys_clk), .resetn(resetn),
    .reg_index(reg_index), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .an_complete(an_complete), .remote_fault(remote_fault), .link_up(link_up), .jabber(jabber),
    .phy_soft_reset(phy_soft_reset), .an_restart(an_restart), .loopback(loopback), .power_down(power_down),
    .an_enable(an_enable), .full_duplex(full_duplex), .speed(speed), .adv_word(adv_word));
  task automatic rchk(input logic [4:0] i, input logic [15:0] e);
    gbr_mac_model_inst.rd(i, v);
    `CHK("rdata", e, v)
  endtask : rchk
  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim
  task automatic check_defaults;
    rchk(IDX_CTRL, 16'h1040);
    rchk(IDX_STAT, 16'h7909);
    rchk(5'h10, 16'h0000);
    rchk(IDX_ADV, 16'h01e1);
    `CHK("speed", 2'b10, speed)
  endtask : check_defaults
  task automatic check_forced;
    gbr_mac_model_inst.wr(IDX_CTRL, 16'h65bf);
    rchk(IDX_CTRL, 16'h6140);
    `CHK("loopback", 1'b1, loopback)
    `CHK("speed", 2'b11, speed)
    `CHK("duplex", 1'b1, full_duplex)
    gbr_mac_model_inst.wr(IDX_CTRL, 16'h1100);
    rchk(IDX_CTRL, 16'h1140);
    `CHK("aneg duplex", 1'b0, full_duplex)
    `CHK("aneg speed", 2'b10, speed)
    gbr_mac_model_inst.wr(IDX_CTRL, 16'h0000);
    gbr_mac_model_inst.wr(IDX_CTRL, 16'h0800);
    rchk(IDX_CTRL, 16'h0840);
    `CHK("power down", 1'b1, power_down)
  endtask : check_forced
  task automatic check_restart;
    gbr_mac_model_inst.wr(IDX_CTRL, 16'h1200);
    @(negedge sys_clk);
    `CHK("restart hi", 1'b1, an_restart)
    @(negedge sys_clk);
    `CHK("restart lo", 1'b0, an_restart)
    rchk(IDX_CTRL, 16'h1040);
  endtask : check_restart
  task automatic check_ids;
    gbr_mac_model_inst.wr(IDX_ID_HI, 16'h0000);
    gbr_mac_model_inst.wr(IDX_ID_LO, 16'hffff);
    gbr_mac_model_inst.wr(IDX_ADV, 16'hffff);
    rchk(IDX_ID_HI, T_OUI_HI);
    rchk(IDX_ID_LO, {T_OUI_LO, 10'h3ff});
    rchk(IDX_ADV, 16'hadff);
  endtask : check_ids
  task automatic check_status;
    an_complete  <= 1'b1;
    remote_fault <= 1'b1;
    jabber       <= 1'b1;
    link_up      <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rchk(IDX_STAT, 16'h793b);
    rchk(IDX_STAT, 16'h793f);
    link_up <= 1'b0;
    repeat (3) @(posedge sys_clk);
    link_up <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rchk(IDX_STAT, 16'h793b);
    rchk(IDX_STAT, 16'h793f);
  endtask : check_status
  task automatic check_soft_reset;
    gbr_mac_model_inst.wr(IDX_CTRL, 16'h8000);
    @(negedge sys_clk);
    `CHK("soft reset", 1'b1, phy_soft_reset)
    for (n = 0; n < 12 && phy_soft_reset === 1'b1; n++) begin
      @(negedge sys_clk);
    end
    if (n == 12) begin
      errors++;
      end_sim();
    end
    `CHK("adv after reset", ADV_RESET, adv_word)
    rchk(IDX_CTRL, 16'h1040);
    rchk(IDX_ID_LO, {T_OUI_LO, MODEL_RESET, REV_RESET});
  endtask : check_soft_reset
  initial begin
    repeat (5) @(posedge sys_clk);
    resetn <= 1'b1;
    check_defaults();
    check_forced();
    check_restart();
    check_ids();
    check_status();
    check_soft_reset();
    end_sim();
  end
endmodule : tb_gbr_regs
